// ---- sffe_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
package sffe_pkg;
  localparam int PIN_COUNT = 6;
  // Bit positions of the pin group carried through the synchroniser
  localparam int PIN_SCK = 0;
  localparam int PIN_CE = 1;
  localparam int PIN_IO0 = 2;
  localparam int PIN_IO1 = 3;
  localparam int PIN_HOLD = 4;
  localparam int PIN_WP = 5;
  localparam logic [PIN_COUNT-1:0] PIN_IDLE = 6'h3_3;
  // Command codes
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST = 8'h0B;
  localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
  localparam logic [7:0] OP_DUAL_IO = 8'hBB;
  localparam logic [7:0] OP_RD_STAT = 8'h05;
  localparam logic [7:0] OP_WR_STAT = 8'h01;
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_WR_DIS = 8'h04;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_ERASE_SEC = 8'h20;
  localparam logic [7:0] OP_ERASE_BLK = 8'hD8;
  localparam logic [7:0] OP_ERASE_CHIP = 8'hC7;
  // Sequence lengths in bits or clocks
  localparam logic [5:0] BYTE_BITS = 6'h0_8;
  localparam logic [5:0] ADDR_BITS = 6'h1_8;
  localparam logic [5:0] DUMMY_CLKS = 6'h0_8;
  localparam logic [5:0] MODE_CLKS = 6'h0_4;
  localparam logic [5:0] DUAL_CLKS = 6'h0_4;
  // Status byte layout
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_LOCK = 7;
  // Array geometry: 256 sectors of 4 KB inside 16 blocks of 64 KB
  localparam int ADDR_W = 20;
  localparam int SEC_LO = 12;
  localparam int BLK_LO = 16;
  localparam logic [1:0] ERASE_SECTOR = 2'h0;
  localparam logic [1:0] ERASE_BLOCK = 2'h1;
  localparam logic [1:0] ERASE_CHIP = 2'h2;
  typedef enum logic [6:0] {
    S_IDLE = 7'h0_1,
    S_CMD = 7'h0_2,
    S_ADDR = 7'h0_4,
    S_DUMMY = 7'h0_8,
    S_OUT = 7'h1_0,
    S_IN = 7'h2_0,
    S_IGNORE = 7'h4_0
  } sffe_state_type;
endpackage

module sffe_sync (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [sffe_pkg::PIN_COUNT-1:0] pinRaw,
  output logic [sffe_pkg::PIN_COUNT-1:0] pinSync
);
  import sffe_pkg::*;
  typedef struct packed {
    logic [PIN_COUNT-1:0] first;
    logic [PIN_COUNT-1:0] second;
  } sffe_sync_type;
  sffe_sync_type r, n;

  // Two flops per pin; only the second stage is visible
  always_comb begin
    n.first = pinRaw;
    n.second = r.first;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      r <= '{first: PIN_IDLE, second: PIN_IDLE};
    end else begin
      r <= n;
    end
  end

  assign pinSync = r.second;
endmodule
`default_nettype wire

// ---- sffe_front_end.sv ----
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Capture input bits on rising clock while selected
// - Change output bits only on falling edges
// - New command only after select falls
// - Select high: standby, ignore clock and data
// - Works in clock modes 0 and 3
// - Dual mode uses both lines bidirectionally
// - 3B dual output, BB dual address and data
// - 256 sectors of 4K, 16 blocks of 64K
// - Pause suspends transfer, keeps position
// - Write-protect pin enables lock bit
// - Busy bit shown, host polls it
// - Pause enters and leaves only with clock low
// - Paused: output released, inputs ignored
// - Status bit 0 is busy flag
module sffe_front_end (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ceN,
  input wire logic sck,
  input wire logic io0In,
  output logic io0Out,
  output logic io0Oe,
  input wire logic io1In,
  output logic io1Out,
  output logic io1Oe,
  input wire logic holdN,
  input wire logic wpN,
  input wire logic arrayBusy,
  input wire logic [7:0] arrayRdData,
  output logic [sffe_pkg::ADDR_W-1:0] arrayAddr,
  output logic progReq,
  output logic [7:0] progData,
  output logic eraseReq,
  output logic [1:0] eraseKind,
  output logic [7:0] eraseSector,
  output logic [3:0] eraseBlock
);
  import sffe_pkg::*;

  typedef struct packed {
    sffe_state_type state;
    logic sckPrev;
    logic cePrev;
    logic held;
    logic [5:0] cnt;
    logic [7:0] op;
    logic [23:0] sh;
    logic [ADDR_W-1:0] addr;
    logic bump;
    logic [7:0] outSh;
    logic drv0;
    logic drv1;
    logic wel;
    logic [3:0] prot;
    logic lock;
    logic armed;
    logic io0Out;
    logic io0Oe;
    logic io1Out;
    logic io1Oe;
    logic progReq;
    logic [7:0] progData;
    logic eraseReq;
    logic [1:0] eraseKind;
  } sffe_regs_type;

  sffe_regs_type r, n;
  logic [PIN_COUNT-1:0] pins;
  logic sckS, ceS, io0S, io1S, holdS, wpS;
  logic rise, fall;
  logic [7:0] outByte;

  // Every pin crosses into the core clock through two flops
  sffe_sync u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pinRaw({wpN, holdN, io1In, io0In, ceN, sck}),
    .pinSync(pins)
  );

  assign sckS = pins[PIN_SCK];
  assign ceS = pins[PIN_CE];
  assign io0S = pins[PIN_IO0];
  assign io1S = pins[PIN_IO1];
  assign holdS = pins[PIN_HOLD];
  assign wpS = pins[PIN_WP];

  // Dual data phase for the two dual reads
  function automatic logic dualData(input logic [7:0] op);
    dualData = (op == OP_DUAL_OUT) || (op == OP_DUAL_IO);
  endfunction

  // Address arrives on both lines only for the dual I/O read
  function automatic logic dualAddr(input logic [7:0] op);
    dualAddr = (op == OP_DUAL_IO);
  endfunction

  // Status byte: busy, latch, protection field, zero, lock
  function automatic logic [7:0] statusByte(input logic busy, input logic wel,
                                            input logic [3:0] prot, input logic lock);
    logic [7:0] s;
    s = 8'h0_0;
    s[ST_BUSY] = busy;
    s[ST_WEL] = wel;
    s[ST_BP_LO +: 4] = prot;
    s[ST_LOCK] = lock;
    statusByte = s;
  endfunction

  // Edges seen by the core clock; none count while paused
  assign rise = sckS & ~r.sckPrev & ~r.held;
  assign fall = ~sckS & r.sckPrev & ~r.held;

  always_comb begin
    n = r;
    n.sckPrev = sckS;
    n.cePrev = ceS;
    n.progReq = 1'b0;
    n.eraseReq = 1'b0;
    n.bump = 1'b0;
    outByte = 8'h0_0;
    // Address steps one core cycle after a byte used it
    if (r.bump) begin
      if (r.op == OP_PROG) begin
        n.addr[7:0] = r.addr[7:0] + 8'h0_1;
      end else begin
        n.addr = r.addr + {{(ADDR_W-1){1'b0}}, 1'b1};
      end
    end
    if (ceS) begin
      // Deselected: finish accepted writes and fall to standby
      if (!r.cePrev && r.armed) begin
        n.wel = 1'b0;
        if (r.op == OP_ERASE_SEC || r.op == OP_ERASE_BLK || r.op == OP_ERASE_CHIP) begin
          n.eraseReq = 1'b1;
          n.eraseKind = (r.op == OP_ERASE_SEC) ? ERASE_SECTOR :
                        (r.op == OP_ERASE_BLK) ? ERASE_BLOCK : ERASE_CHIP;
        end
      end
      n.state = S_IDLE;
      n.held = 1'b0;
      n.armed = 1'b0;
      n.drv0 = 1'b0;
      n.drv1 = 1'b0;
    end else if (r.cePrev) begin
      // Select fell: start a fresh command
      n.state = S_CMD;
      n.cnt = 6'h0_0;
      n.armed = 1'b0;
      n.drv0 = 1'b0;
      n.drv1 = 1'b0;
    end else begin
      // Pause enters and leaves only while the clock is low
      if (!sckS && !holdS) begin
        n.held = 1'b1;
      end else if (!sckS && holdS) begin
        n.held = 1'b0;
      end
      unique case (r.state)
        S_IDLE, S_IGNORE: begin
        end
        S_CMD: begin
          if (rise) begin
            n.sh = {r.sh[22:0], io0S};
            n.cnt = r.cnt + 6'h0_1;
            if (r.cnt == BYTE_BITS - 6'h0_1) begin
              n.op = {r.sh[6:0], io0S};
              n.cnt = 6'h0_0;
              n.state = S_IGNORE;
              // Only the status read is served while the array is busy
              if (n.op == OP_RD_STAT) begin
                n.state = S_OUT;
              end else if (arrayBusy) begin
                n.state = S_IGNORE;
              end else if (n.op == OP_WR_EN) begin
                n.wel = 1'b1;
              end else if (n.op == OP_WR_DIS) begin
                n.wel = 1'b0;
              end else if (n.op == OP_WR_STAT) begin
                n.state = S_IN;
              end else if (n.op == OP_ERASE_CHIP) begin
                n.armed = r.wel && (r.prot == 4'h0);
              end else if (n.op == OP_READ || n.op == OP_FAST || n.op == OP_PROG ||
                           dualData(n.op) || n.op == OP_ERASE_SEC || n.op == OP_ERASE_BLK) begin
                n.state = S_ADDR;
              end
            end
          end
        end
        S_ADDR: begin
          if (rise) begin
            if (dualAddr(r.op)) begin
              n.sh = {r.sh[21:0], io1S, io0S};
              n.cnt = r.cnt + 6'h0_2;
            end else begin
              n.sh = {r.sh[22:0], io0S};
              n.cnt = r.cnt + 6'h0_1;
            end
            if (n.cnt == ADDR_BITS) begin
              n.addr = n.sh[ADDR_W-1:0];
              n.cnt = 6'h0_0;
              if (r.op == OP_READ) begin
                n.state = S_OUT;
              end else if (r.op == OP_PROG) begin
                n.state = S_IN;
                n.armed = r.wel;
              end else if (r.op == OP_ERASE_SEC || r.op == OP_ERASE_BLK) begin
                n.state = S_IGNORE;
                n.armed = r.wel;
              end else begin
                n.state = S_DUMMY;
              end
            end
          end
        end
        S_DUMMY: begin
          if (rise) begin
            n.cnt = r.cnt + 6'h0_1;
            if (n.cnt == (dualAddr(r.op) ? MODE_CLKS : DUMMY_CLKS)) begin
              n.cnt = 6'h0_0;
              n.state = S_OUT;
            end
          end
        end
        S_OUT: begin
          // Bits leave on falling edges, one or two at a time
          if (fall) begin
            if (r.cnt == 6'h0_0) begin
              outByte = (r.op == OP_RD_STAT) ?
                        statusByte(arrayBusy, r.wel, r.prot, r.lock) : arrayRdData;
              n.bump = (r.op != OP_RD_STAT);
            end else begin
              outByte = r.outSh;
            end
            n.io1Out = outByte[7];
            n.drv1 = 1'b1;
            if (dualData(r.op)) begin
              n.io0Out = outByte[6];
              n.drv0 = 1'b1;
              n.outSh = {outByte[5:0], 2'h0};
              n.cnt = (r.cnt == DUAL_CLKS - 6'h0_1) ? 6'h0_0 : r.cnt + 6'h0_1;
            end else begin
              n.outSh = {outByte[6:0], 1'b0};
              n.cnt = (r.cnt == BYTE_BITS - 6'h0_1) ? 6'h0_0 : r.cnt + 6'h0_1;
            end
          end
        end
        S_IN: begin
          if (rise) begin
            n.sh = {r.sh[22:0], io0S};
            n.cnt = r.cnt + 6'h0_1;
            if (n.cnt == BYTE_BITS) begin
              n.cnt = 6'h0_0;
              if (r.op == OP_WR_STAT) begin
                n.state = S_IGNORE;
                // Lock bit only counts while write-protect is low
                if (r.wel && (wpS || !r.lock)) begin
                  n.prot = n.sh[ST_BP_LO +: 4];
                  n.lock = n.sh[ST_LOCK];
                  n.armed = 1'b1;
                end
              end else if (r.armed) begin
                n.progReq = 1'b1;
                n.progData = n.sh[7:0];
                n.bump = 1'b1;
              end
            end
          end
        end
        default: begin
          n.state = S_IDLE;
        end
      endcase
    end
    // Drivers release while paused or deselected
    n.io0Oe = n.drv0 & ~n.held;
    n.io1Oe = n.drv1 & ~n.held;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      r <= '{state: S_IDLE, sckPrev: 1'b1, cePrev: 1'b1, held: 1'b0, cnt: 6'h0_0,
             op: 8'h0_0, sh: 24'h00_0000, addr: '0, bump: 1'b0, outSh: 8'h0_0,
             drv0: 1'b0, drv1: 1'b0, wel: 1'b0, prot: 4'h0, lock: 1'b0,
             armed: 1'b0, io0Out: 1'b0, io0Oe: 1'b0, io1Out: 1'b0, io1Oe: 1'b0,
             progReq: 1'b0, progData: 8'h0_0, eraseReq: 1'b0, eraseKind: 2'h0};
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state flops
  assign io0Out = r.io0Out;
  assign io0Oe = r.io0Oe;
  assign io1Out = r.io1Out;
  assign io1Oe = r.io1Oe;
  assign arrayAddr = r.addr;
  assign progReq = r.progReq;
  assign progData = r.progData;
  assign eraseReq = r.eraseReq;
  assign eraseKind = r.eraseKind;
  assign eraseSector = r.addr[SEC_LO +: 8];
  assign eraseBlock = r.addr[BLK_LO +: 4];
endmodule
`default_nettype wire

// ---- sffe_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
// Pin-side checks of the front end
module sffe_monitor (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ceN,
  input wire logic sck,
  input wire logic holdN,
  input wire logic io0Oe,
  input wire logic io1Out,
  input wire logic io1Oe,
  input wire logic eraseReq,
  input wire logic progReq,
  input wire logic [sffe_pkg::ADDR_W-1:0] arrayAddr,
  input wire logic [7:0] eraseSector,
  input wire logic [3:0] eraseBlock
);
  import sffe_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Deselect or pause held long enough to pass the synchroniser
  sequence desel_s;
    ceN [*6];
  endsequence
  sequence pause_s;
    (!holdN && !ceN) [*6];
  endsequence
  desel_idle_a: assert property (desel_s |-> !io1Oe && !io0Oe)
    else $error("line driven while deselected");
  pause_float_a: assert property (pause_s |-> !io1Oe && !io0Oe)
    else $error("line driven while paused");
  out_fall_a: assert property (
    io1Oe && $past(io1Oe) && $changed(io1Out) |-> !$past(sck, 3))
    else $error("output bit moved without a clock fall");
  oe_rise_a: assert property ($rose(io1Oe) |-> !$past(ceN, 3) && !$past(sck, 3))
    else $error("output enabled outside a selected low clock");
  dual_pair_a: assert property (io0Oe |-> io1Oe)
    else $error("second line driven alone");
  erase_pulse_a: assert property (eraseReq |-> $past(ceN, 2) ##1 !eraseReq)
    else $error("erase request not one pulse after deselect");
  erase_map_a: assert property (eraseReq |->
    eraseSector == arrayAddr[19:12] && eraseBlock == arrayAddr[19:16])
    else $error("erase sector or block field wrong");
  prog_pulse_a: assert property (progReq |=> !progReq)
    else $error("program request longer than one cycle");
  reset_quiet_a: assert property (disable iff (1'b0)
    sys_rst |=> !io1Oe && !io0Oe && !eraseReq && !progReq)
    else $error("outputs active after reset");
endmodule
bind sffe_front_end sffe_monitor mon (.core_clk, .sys_rst, .ceN, .sck, .holdN, .io0Oe,
  .io1Out, .io1Oe, .eraseReq, .progReq, .arrayAddr, .eraseSector, .eraseBlock);
`default_nettype wire

// ---- sffe_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Host controller: select, clock and data, changed at core clock falls
module sffe_host_model (
  input wire logic core_clk,
  input wire logic io0Out,
  input wire logic io0Oe,
  input wire logic io1Out,
  input wire logic io1Oe,
  output var logic ceN,
  output var logic sck,
  output logic io0In,
  output logic io1In
);
  logic cpol = 1'b0;
  logic [1:0] hostOe = 2'h1;
  logic [1:0] hostD = 2'h0;
  logic junk = 1'b0;
  initial ceN = 1'b1;
  initial sck = 1'b0;
  // Undriven lines toggle so stale bits never pass
  always @(posedge core_clk) junk <= ~junk;
  // Wire level from both parties' enables
  assign io0In = io0Oe ? io0Out : (hostOe[0] ? hostD[0] : junk);
  assign io1In = io1Oe ? io1Out : (hostOe[1] ? hostD[1] : ~junk);
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Park clock at idle level, then select
  task automatic start();
    sck = cpol;
    tick(4);
    ceN = 1'b0;
    tick(4);
  endtask
  // Park clock, then deselect after the last bit
  task automatic stop();
    sck = cpol;
    tick(4);
    ceN = 1'b1;
    hostOe = 2'h1;
    tick(8);
  endtask
  // One clock: data set in low phase, sampled before the rise
  task automatic clk1(input logic [1:0] tx, output logic [1:0] rx);
    sck = 1'b0;
    hostD = tx;
    tick(4);
    rx = {io1In, io0In};
    sck = 1'b1;
    tick(4);
  endtask
  // One byte, high bit first, one or two bits per clock
  task automatic xbyte(input logic [7:0] tx, input logic dual, output logic [7:0] rx);
    logic [1:0] b;
    for (int i = 7; i >= 0; i -= (dual ? 2 : 1)) begin
      clk1(dual ? tx[i -: 2] : {1'b0, tx[i]}, b);
      if (dual) rx[i -: 2] = b;
      else rx[i] = b[1];
    end
  endtask
endmodule
`default_nettype wire

// ---- tb_spi_flash_serial_front_end.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_spi_flash_serial_front_end;
  import sffe_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic holdN = 1'b1;
  logic wpN = 1'b1;
  logic arrayBusy;
  logic busyForce = 1'b0;
  int busyLeft = 0;
  int progs = 0;
  logic [15:0] seenProg;
  logic ceN, sck, io0In, io1In, io0Out, io0Oe, io1Out, io1Oe, progReq, eraseReq;
  logic [ADDR_W-1:0] arrayAddr;
  logic [7:0] arrayRdData, progData, eraseSector, r;
  logic [1:0] eraseKind, seenKind, b;
  logic [3:0] eraseBlock;
  logic [11:0] seenMap;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;
  int erases = 0;
  // Array holds a pattern of its address
  assign arrayRdData = arrayAddr[7:0] ^ 8'h5A;
  // Array engine stand-in: busy for a while after each erase, or when forced
  assign arrayBusy = busyForce || (busyLeft != 0);
  sffe_host_model host (.core_clk, .io0Out, .io0Oe, .io1Out, .io1Oe, .ceN, .sck, .io0In,
    .io1In);
  sffe_front_end uut (.core_clk, .sys_rst, .ceN, .sck, .io0In, .io0Out, .io0Oe, .io1In,
    .io1Out, .io1Oe, .holdN, .wpN, .arrayBusy, .arrayRdData, .arrayAddr, .progReq,
    .progData, .eraseReq, .eraseKind, .eraseSector, .eraseBlock);
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  // Record erase and program pulses where settled; cut a hang short
  always @(negedge core_clk) begin
    cycles++;
    if (eraseReq) begin
      erases++;
      seenKind = eraseKind;
      seenMap = {eraseSector, eraseBlock};
      busyLeft <= 100;
    end else if (busyLeft != 0) begin
      busyLeft <= busyLeft - 1;
    end
    if (progReq) begin
      progs++;
      seenProg = {arrayAddr[7:0], progData};
    end
    if (cycles == 20000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] op, input logic [23:0] ad, input int n);
    logic [31:0] w;
    // A fourth byte is the zero dummy byte
    w = {ad, 8'h00};
    host.start();
    host.xbyte(op, 1'b0, r);
    for (int i = 0; i < n; i++) host.xbyte(w[31 - 8 * i -: 8], 1'b0, r);
  endtask
  task automatic rdstat();
    cmd(OP_RD_STAT, 24'h0, 0);
    host.xbyte(8'h00, 1'b0, r);
    host.stop();
  endtask
  task automatic wrstat(input logic [7:0] v);
    cmd(OP_WR_EN, 24'h0, 0);
    host.stop();
    cmd(OP_WR_STAT, 24'h0, 0);
    host.xbyte(v, 1'b0, r);
    host.stop();
  endtask
  // Idle clocking, aborted command, then reads in both clock modes
  task automatic t_read();
    for (int i = 0; i < 16; i++) host.clk1(2'h0, b);
    chk(io1Oe, 1'b0);
    for (int m = 0; m < 2; m++) begin
      host.cpol = m[0];
      cmd(OP_READ, 24'h01_2345, 1);
      host.stop();
      cmd(OP_READ, 24'h01_2FFF, 3);
      host.xbyte(8'h00, 1'b0, r);
      chk(r, 8'hFF ^ 8'h5A);
      host.xbyte(8'h00, 1'b0, r);
      chk(r, 8'h00 ^ 8'h5A);
      host.stop();
    end
    $display("read test done");
  endtask
  // Dual output, then address and data on both lines
  task automatic t_dual();
    cmd(OP_DUAL_OUT, 24'h00_0123, 4);
    host.hostOe = 2'h0;
    host.xbyte(8'h00, 1'b1, r);
    chk(r, 8'h23 ^ 8'h5A);
    host.stop();
    cmd(OP_DUAL_IO, 24'h0, 0);
    host.hostOe = 2'h3;
    for (int i = 0; i < 4; i++) host.xbyte(i == 3 ? 8'h00 : 8'h04, 1'b1, r);
    host.hostOe = 2'h0;
    host.xbyte(8'h00, 1'b1, r);
    chk(r, 8'h04 ^ 8'h5A);
    host.stop();
    $display("dual test done");
  endtask
  // Busy polling, then the lock bit under both protect levels
  task automatic t_status();
    busyForce = 1'b1;
    rdstat();
    chk(r[0], 1'b1);
    cmd(OP_WR_EN, 24'h0, 0);
    host.stop();
    rdstat();
    chk(r[1:0], 2'h1);
    busyForce = 1'b0;
    rdstat();
    chk(r[0], 1'b0);
    wrstat(8'h80);
    for (int w = 0; w < 2; w++) begin
      wpN = w[0];
      wrstat(8'h00);
      rdstat();
      chk(r[7], w == 0);
    end
    $display("status test done");
  endtask
  // Chip erase without enable is refused; then each erase kind
  task automatic t_erase();
    logic [7:0] ops [3] = '{OP_ERASE_SEC, OP_ERASE_BLK, OP_ERASE_CHIP};
    int n;
    int k;
    for (int j = 0; j < 4; j++) begin
      k = (j + 2) % 3;
      n = erases;
      if (j > 0) begin
        cmd(OP_WR_EN, 24'h0, 0);
        host.stop();
      end
      cmd(ops[k], 24'h0A_B123, k == 2 ? 0 : 3);
      host.stop();
      chk(erases - n, j > 0);
      if (j > 0) chk(seenKind, k);
      if (j > 0 && k < 2) chk(seenMap, 12'hABA);
      // Poll busy until the erase is over
      if (j > 0) begin
        rdstat();
        chk(r[0], 1'b1);
        for (int p = 0; p < 4 && r[0]; p++) rdstat();
        chk(r[0], 1'b0);
      end
    end
    $display("erase test done");
  endtask
  // Page program with wrap, then a program refused without enable
  task automatic t_prog();
    int n;
    n = progs;
    cmd(OP_WR_EN, 24'h0, 0);
    host.stop();
    cmd(OP_PROG, 24'h00_01FF, 3);
    host.xbyte(8'hC3, 1'b0, r);
    chk(seenProg, 16'hFFC3);
    host.xbyte(8'h3C, 1'b0, r);
    chk(seenProg, 16'h003C);
    chk(arrayAddr[15:0], 16'h0101);
    host.stop();
    rdstat();
    chk(r[1], 1'b0);
    cmd(OP_PROG, 24'h00_0010, 3);
    host.xbyte(8'hA5, 1'b0, r);
    host.stop();
    chk(progs - n, 2);
    $display("program test done");
  endtask
  // Pause mid-byte with clock activity, then finish the byte
  task automatic t_hold();
    cmd(OP_READ, 24'h00_0077, 3);
    host.sck = 1'b0;
    host.tick(4);
    holdN = 1'b0;
    host.tick(6);
    chk(io1Oe, 1'b0);
    host.clk1(2'h3, b);
    host.sck = 1'b0;
    host.tick(4);
    holdN = 1'b1;
    host.tick(6);
    chk(io1Oe, 1'b1);
    r[7] = io1In;
    host.sck = 1'b1;
    host.tick(4);
    for (int i = 6; i >= 0; i--) begin
      host.clk1(2'h0, b);
      r[i] = b[1];
    end
    chk(r, 8'h77 ^ 8'h5A);
    host.stop();
    $display("hold test done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    host.tick(3);
    sys_rst = 1'b0;
    t_read();
    t_dual();
    t_status();
    t_erase();
    t_prog();
    t_hold();
    stop_test();
  end
endmodule
`default_nettype wire
